//--- logic/atsc_defines.svh
/*
 * Register addresses, field positions and
 * reset values for the task-file status and control block.
 * Assumes the includer works in an 8-bit task-file data path.
 */
// Notes on behaviour
// - Drive/head bit 6 picks addressing: 0 cylinder/head/sector, 1 block.
// - Block address is head nibble, cylinder high and low, sector number.
// - Drive/head bits 3-0 hold the head number, bit 3 most significant.
// - Drive/head bit 4 selects unit; device answers only when it matches.
// - Reading the primary status clears the pending host interrupt.
// - Busy is set during internal work; other status bits then invalid.
// - Ready set with seek complete when requests accepted, else cleared.
// - After an error, ready holds its value until primary status is read.
// - Status bit 5 flags a write fault.
// - Status bit 4 flags seek complete.
// - Status bit 3 flags that data may move through the data register.
// - Status bit 2 flags a corrected data error.
// - Status bit 1 always reads zero.
// - Status bit 0 flags the last command ended in error.
// - Shadow status equals primary status and leaves the interrupt alone.
// - Host loads parameters while ready, then the command write starts work.
// - Writing one to control bit 2 soft-resets the disk control logic.
// - Interrupt pin driven when selected and either enabled or in memory mode, else high impedance.
// - Readback bits 5-2 are inverted head bits; bit 7 undriven, 6 unused.
// - Readback bit 1 low when unit 1 selected, bit 0 when unit 0 selected.
`ifndef ATSC_DEFINES_SVH
`define ATSC_DEFINES_SVH

// Address {cs2_n, cs1_n, a2, a1, a0}
`define ATSC_ADR_SECNUM 5'h13
`define ATSC_ADR_CYLLO 5'h14
`define ATSC_ADR_CYLHI 5'h15
`define ATSC_ADR_DRVHEAD 5'h16
`define ATSC_ADR_STATUS 5'h17
`define ATSC_ADR_SHADOW 5'h0e
`define ATSC_ADR_READBACK 5'h0f

`define ATSC_DH_LBA 6
`define ATSC_DH_UNIT 4
`define ATSC_DH_HEAD 3:0
`define ATSC_DC_SOFT_RESET_BIT 2
`define ATSC_DC_INTERRUPT_DISABLE_BIT 1

`define ATSC_DH_RESET 8'ha0
`define ATSC_DC_RESET 8'h08
`define ATSC_BYTE_ZERO 8'h00
`define ATSC_ONE_BIT 1'b1

`endif

//--- logic/atsc_pkg.sv
/*
 * Types shared by the task-file status and control block.
 * Assumes the defines header is compiled alongside.
 */
package atsc_pkg;

    typedef struct packed {
        logic busy;
        logic ready;
        logic write_fault;
        logic seek_done;
        logic xfer_req;
        logic corrected;
        logic index;
        logic error;
    } atsc_status_s;

    typedef struct packed {
        logic ready;
        logic write_fault;
        logic seek_done;
        logic xfer_req;
        logic corrected;
        logic error;
    } atsc_engine_s;

    typedef enum logic [1:0] {
        ATSC_IDLE = 2'b01,
        ATSC_BUSY = 2'b10
    } atsc_state_e;

endpackage

//--- logic/atsc_task_file.sv
/*
 * Drive/head, status, shadow status, command entry, device control
 * and legacy readback registers of the ATA task file.
 * Assumes host strobes arrive asynchronously and are synchronised here;
 * the command engine runs on clk_in and reports through engine_in.
 */
`timescale 1ns/1ps
`include "atsc_defines.svh"

module atsc_task_file
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic unit_identity_config_in,
    input wire logic memory_mode_in,
    input wire logic cs1_n_in,
    input wire logic cs2_n_in,
    input wire logic [2:0] addr_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic [7:0] data_in,
    input wire logic [7:0] sector_number_in,
    input wire logic [7:0] cylinder_low_in,
    input wire logic [7:0] cylinder_high_in,
    input wire atsc_pkg::atsc_engine_s engine_in,
    input wire logic engine_done_in,
    input wire logic engine_irq_in,
    output logic [7:0] data_out,
    output logic data_oe_out,
    output logic readback_bit7_oe_out,
    output logic host_interrupt_pin_out,
    output logic host_interrupt_pin_oe_out,
    output logic block_address_mode_out,
    output logic [27:0] block_address_out,
    output logic [3:0] head_number_bits_out,
    output logic command_start_out,
    output logic [7:0] command_code_out,
    output logic soft_reset_out
);
    import atsc_pkg::*;

    // ****************************************************
    // Pin synchronisers and strobe edges
    // ****************************************************
    logic [9:0] pin_s1_r;
    logic [9:0] pin_s2_r;
    logic [9:0] pin_s3_r;
    logic [7:0] wdata_r;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pin_s1_r <= 10'h3ff;
            pin_s2_r <= 10'h3ff;
            pin_s3_r <= 10'h3ff;
        end
        else
        begin
            pin_s1_r <= {cs2_n_in, cs1_n_in, addr_in, rd_n_in, wr_n_in,
                         unit_identity_config_in, memory_mode_in, 1'b1};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    logic [7:0] data_s1_r;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            data_s1_r <= `ATSC_BYTE_ZERO;
            wdata_r <= `ATSC_BYTE_ZERO;
        end
        else
        begin
            data_s1_r <= data_in;
            wdata_r <= data_s1_r;
        end
    end

    logic [4:0] adr;
    logic unit_cfg;
    logic mem_mode;
    logic rd_go;
    logic wr_go;
    logic rd_active;

    assign adr = pin_s2_r[9:5];
    assign unit_cfg = pin_s2_r[2];
    assign mem_mode = pin_s2_r[1];
    assign rd_active = !pin_s2_r[4];
    // Write takes effect on the trailing (rising) strobe edge
    assign wr_go = pin_s2_r[3] && !pin_s3_r[3];
    assign rd_go = !pin_s2_r[4] && pin_s3_r[4];

    // ****************************************************
    // Drive/head and device control registers
    // ****************************************************
    logic [7:0] drive_head_select_r;
    logic [7:0] interface_control_r;
    logic selected;

    // Bits 7 and 5 are kept as the host wrote them
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            drive_head_select_r <= `ATSC_DH_RESET;
        else if (wr_go && adr == `ATSC_ADR_DRVHEAD)
            drive_head_select_r <= wdata_r;
    end

    // Bits 7-4 stored but never used
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            interface_control_r <= `ATSC_DC_RESET;
        else if (wr_go && adr == `ATSC_ADR_SHADOW)
            interface_control_r <= wdata_r;
    end

    assign selected = drive_head_select_r[`ATSC_DH_UNIT] == unit_cfg;

    // ****************************************************
    // Command engine handshake and busy tracking
    // ****************************************************
    atsc_state_e state_r;
    logic cmd_go;
    logic soft_reset_bit_go;

    // Command write only taken by the selected unit
    assign cmd_go = wr_go && adr == `ATSC_ADR_STATUS && selected;
    assign soft_reset_bit_go = wr_go && adr == `ATSC_ADR_SHADOW
                     && wdata_r[`ATSC_DC_SOFT_RESET_BIT];

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            state_r <= ATSC_IDLE;
        else if (cmd_go || soft_reset_bit_go)
            state_r <= ATSC_BUSY;
        else
        begin
            unique case (state_r)
                ATSC_IDLE: state_r <= ATSC_IDLE;
                ATSC_BUSY:
                    if (engine_done_in)
                        state_r <= ATSC_IDLE;
                default: state_r <= ATSC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            command_start_out <= 1'b0;
            command_code_out <= `ATSC_BYTE_ZERO;
            soft_reset_out <= 1'b0;
        end
        else
        begin
            command_start_out <= cmd_go;
            soft_reset_out <= soft_reset_bit_go;
            if (cmd_go)
                command_code_out <= wdata_r;
        end
    end

    // ****************************************************
    // Status contents
    // ****************************************************
    atsc_status_s status_r;
    logic ready_hold_r;
    logic err_done;
    logic stat_rd;

    assign err_done = engine_done_in && engine_in.error;
    // Only a primary status read by the selected unit counts
    assign stat_rd = rd_go && adr == `ATSC_ADR_STATUS && selected;

    // Ready frozen after an error until primary status read
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            ready_hold_r <= 1'b0;
        else if (err_done)
            ready_hold_r <= 1'b1;
        else if (stat_rd)
            ready_hold_r <= 1'b0;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            status_r <= '0;
        else
        begin
            status_r.busy <= state_r == ATSC_BUSY;
            // Ready keeps its old value on the error completion edge too
            if (!ready_hold_r && !err_done)
                status_r.ready <= engine_in.ready;
            status_r.write_fault <= engine_in.write_fault;
            status_r.seek_done <= engine_in.seek_done;
            status_r.xfer_req <= engine_in.xfer_req;
            status_r.corrected <= engine_in.corrected;
            status_r.index <= 1'b0;
            status_r.error <= engine_in.error;
        end
    end

    // ****************************************************
    // Interrupt pin
    // ****************************************************
    logic irq_pend_r;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            irq_pend_r <= 1'b0;
        else if (engine_irq_in)
            irq_pend_r <= 1'b1;
        else if (stat_rd)
            irq_pend_r <= 1'b0;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            host_interrupt_pin_out <= 1'b0;
            host_interrupt_pin_oe_out <= 1'b0;
        end
        else
        begin
            host_interrupt_pin_out <= irq_pend_r;
            host_interrupt_pin_oe_out <= selected && (mem_mode
                || !interface_control_r[`ATSC_DC_INTERRUPT_DISABLE_BIT]);
        end
    end

    // ****************************************************
    // Host read data and address outputs
    // ****************************************************
    logic [7:0] rd_mux;
    logic [7:0] readback;

    assign readback = {1'b0, 1'b1,
                       ~drive_head_select_r[`ATSC_DH_HEAD],
                       ~(selected && unit_cfg),
                       ~(selected && !unit_cfg)};

    always_comb
    begin
        rd_mux = `ATSC_BYTE_ZERO;
        if (adr == `ATSC_ADR_DRVHEAD)
            rd_mux = drive_head_select_r;
        else if (adr == `ATSC_ADR_STATUS || adr == `ATSC_ADR_SHADOW)
            rd_mux = status_r;
        else if (adr == `ATSC_ADR_READBACK)
            rd_mux = readback;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            data_out <= `ATSC_BYTE_ZERO;
            data_oe_out <= 1'b0;
            readback_bit7_oe_out <= 1'b0;
        end
        else
        begin
            data_out <= rd_mux;
            data_oe_out <= rd_active && selected
                && (adr == `ATSC_ADR_DRVHEAD || adr == `ATSC_ADR_STATUS
                    || adr == `ATSC_ADR_SHADOW
                    || adr == `ATSC_ADR_READBACK);
            readback_bit7_oe_out <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            block_address_mode_out <= 1'b0;
            block_address_out <= '0;
            head_number_bits_out <= 4'h0;
        end
        else
        begin
            block_address_mode_out <=
                drive_head_select_r[`ATSC_DH_LBA];
            block_address_out <= {drive_head_select_r[`ATSC_DH_HEAD],
                                  cylinder_high_in, cylinder_low_in,
                                  sector_number_in};
            head_number_bits_out <= drive_head_select_r[`ATSC_DH_HEAD];
        end
    end

endmodule

//--- tb/atsc_checker.sv
/* Port assertions for the task-file status and control block.
   Assumes the bench keeps host strobes legal and inputs steady. */
`timescale 1ns/1ps
module atsc_checker
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic [7:0] sector_number_in,
    input wire logic engine_irq_in,
    input wire logic data_oe_out,
    input wire logic readback_bit7_oe_out,
    input wire logic host_interrupt_pin_out,
    input wire logic block_address_mode_out,
    input wire logic [27:0] block_address_out,
    input wire logic [3:0] head_number_bits_out,
    input wire logic command_start_out,
    input wire logic soft_reset_out
);
    // ********
    // Properties
    // ********
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    chk_bit7_undriven: assert property (!readback_bit7_oe_out)
        else $error("readback bit 7 driven");
    chk_lba_low: assert property (block_address_mode_out |->
        block_address_out[7:0] == $past(sector_number_in))
        else $error("block address low byte wrong");
    chk_lba_top: assert property (block_address_mode_out |->
        block_address_out[27:24] == head_number_bits_out)
        else $error("block address top nibble wrong");
    chk_cmd_pulse: assert property (command_start_out |=>
        !command_start_out)
        else $error("command start longer than one cycle");
    chk_soft_reset_bit_pulse: assert property (soft_reset_out |=>
        !soft_reset_out)
        else $error("soft reset longer than one cycle");
    chk_irq_cause: assert property ($rose(host_interrupt_pin_out) |->
        $past(engine_irq_in, 2))
        else $error("interrupt raised without request");
    chk_read_cause: assert property ($rose(data_oe_out) |->
        !$past(rd_n_in))
        else $error("data driven without read strobe");
    chk_cmd_cause: assert property ($rose(command_start_out) |->
        $past(wr_n_in) && $past(wr_n_in, 2))
        else $error("command start before write strobe ended");
endmodule

bind atsc_task_file atsc_checker atsc_checker_inst (.clk_in, .rst_n_in,
    .rd_n_in, .wr_n_in, .sector_number_in, .engine_irq_in, .data_oe_out,
    .readback_bit7_oe_out, .host_interrupt_pin_out, .block_address_mode_out,
    .block_address_out, .head_number_bits_out, .command_start_out,
    .soft_reset_out);

//--- tb/atsc_host_model.sv
/* Host side model issuing task-file reads and writes.
   Assumes a free-running clk_in; strobes move 1 ns after an edge. */
`timescale 1ns/1ps
module atsc_host_model
(
    input wire logic clk_in,
    input wire logic [7:0] rd_data_in,
    input wire logic rd_oe_in,
    output logic cs1_n_out,
    output logic cs2_n_out,
    output logic [2:0] addr_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic [7:0] wdata_out
);
    initial
    begin
        {cs2_n_out, cs1_n_out, addr_out, rd_n_out, wr_n_out} = 7'h7f;
        wdata_out = 8'h00;
    end
    // Strobes low 4 clocks, data held 4 clocks past the rising strobe
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        {cs2_n_out, cs1_n_out, addr_out} = a;
        wdata_out = d;
        wr_n_out = 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        wr_n_out = 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        {cs2_n_out, cs1_n_out} = 2'h3;
        wdata_out = ~d;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d,
        output logic oe);
        @(posedge clk_in);
        #1;
        {cs2_n_out, cs1_n_out, addr_out} = a;
        rd_n_out = 1'b0;
        repeat (5) @(posedge clk_in);
        d = rd_data_in;
        oe = rd_oe_in;
        #1;
        rd_n_out = 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        {cs2_n_out, cs1_n_out} = 2'h3;
    endtask
endmodule

//--- tb/tb_top.sv
/* Self-checking bench for atsc_task_file.
   Assumes the host model and the bound checker are compiled. */
`timescale 1ns/1ps
`include "atsc_defines.svh"
module tb_top;
    import atsc_pkg::*;
    logic clk_in, rst_n_in, unit_identity_config_in, memory_mode_in;
    logic cs1_n_in, cs2_n_in, rd_n_in, wr_n_in, engine_done_in;
    logic [2:0] addr_in;
    logic [7:0] data_in, sector_number_in, cylinder_low_in;
    logic [7:0] cylinder_high_in, data_out, command_code_out, d;
    atsc_engine_s engine_in;
    logic engine_irq_in, data_oe_out, readback_bit7_oe_out, oe;
    logic host_interrupt_pin_out, host_interrupt_pin_oe_out;
    logic block_address_mode_out, command_start_out, soft_reset_out;
    logic [27:0] block_address_out;
    logic [3:0] head_number_bits_out;
    int err_count = 0, n_checks = 0, n_start = 0, n_soft_reset_bit = 0;
    logic [13:0] rows [5] = '{14'h3060, 14'h2850, 14'h2448, 14'h2244,
        14'h0000};
    atsc_task_file atsc_task_file_inst (.clk_in, .rst_n_in,
        .unit_identity_config_in, .memory_mode_in, .cs1_n_in, .cs2_n_in,
        .addr_in, .rd_n_in, .wr_n_in, .data_in, .sector_number_in,
        .cylinder_low_in, .cylinder_high_in, .engine_in, .engine_done_in,
        .engine_irq_in, .data_out, .data_oe_out, .readback_bit7_oe_out,
        .host_interrupt_pin_out, .host_interrupt_pin_oe_out,
        .block_address_mode_out, .block_address_out, .head_number_bits_out,
        .command_start_out, .command_code_out, .soft_reset_out);
    atsc_host_model atsc_host_model_inst (.clk_in, .rd_data_in(data_out),
        .rd_oe_in(data_oe_out), .cs1_n_out(cs1_n_in), .cs2_n_out(cs2_n_in),
        .addr_out(addr_in), .rd_n_out(rd_n_in), .wr_n_out(wr_n_in),
        .wdata_out(data_in));
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        n_start += (command_start_out === 1'b1);
        n_soft_reset_bit += (soft_reset_out === 1'b1);
    end
    task automatic check(input string nm, input logic [7:0] got,
        input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic pulse(input logic done);
        engine_done_in = done;
        engine_irq_in = ~done;
        @(posedge clk_in);
        #1;
        {engine_done_in, engine_irq_in} = 2'h0;
    endtask
    initial
    begin
        #200000;
        err_count++;
        finish_test();
    end
    initial
    begin
        {rst_n_in, unit_identity_config_in, memory_mode_in} = 3'h0;
        {engine_done_in, engine_irq_in} = 2'h0;
        engine_in = atsc_engine_s'(6'h00);
        sector_number_in = 8'h3c;
        cylinder_low_in = 8'h5a;
        cylinder_high_in = 8'h96;
        repeat (12) @(posedge clk_in);
        #1;
        check("rst", {block_address_mode_out, data_oe_out, 2'h0,
            head_number_bits_out}, 8'h00);
        rst_n_in = 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            engine_in = atsc_engine_s'(rows[i][13:8]);
            pulse(1'b1);
            atsc_host_model_inst.rd(`ATSC_ADR_STATUS, d, oe);
            check("status", d, rows[i][7:0]);
            atsc_host_model_inst.rd(`ATSC_ADR_SHADOW, d, oe);
            check("shadow", d, rows[i][7:0]);
            $display("row %0d done", i);
        end
        atsc_host_model_inst.wr(`ATSC_ADR_DRVHEAD, 8'he5);
        check("mode", {7'h0, block_address_mode_out}, 8'h01);
        check("lba3", {4'h0, block_address_out[27:24]}, 8'h05);
        check("lba2", block_address_out[23:16], 8'h96);
        check("lba1", block_address_out[15:8], 8'h5a);
        check("lba0", block_address_out[7:0], 8'h3c);
        atsc_host_model_inst.rd(`ATSC_ADR_READBACK, d, oe);
        check("readback", {1'b0, d[6:0]}, 8'h6a);
        atsc_host_model_inst.wr(`ATSC_ADR_DRVHEAD, 8'ha3);
        check("chs", {7'h0, block_address_mode_out}, 8'h00);
        check("head", {4'h0, head_number_bits_out}, 8'h03);
        $display("drive head test done");
        engine_in = atsc_engine_s'(6'h20);
        pulse(1'b1);
        atsc_host_model_inst.wr(`ATSC_ADR_STATUS, 8'h20);
        check("starts", 8'(n_start), 8'h01);
        check("code", command_code_out, 8'h20);
        atsc_host_model_inst.rd(`ATSC_ADR_STATUS, d, oe);
        check("busy", {d[7], 7'h0}, 8'h80);
        engine_in = atsc_engine_s'(6'h01);
        pulse(1'b1);
        atsc_host_model_inst.rd(`ATSC_ADR_STATUS, d, oe);
        check("held", d, 8'h41);
        atsc_host_model_inst.rd(`ATSC_ADR_STATUS, d, oe);
        check("freed", d, 8'h01);
        $display("command test done");
        atsc_host_model_inst.wr(`ATSC_ADR_DRVHEAD, 8'hb0);
        atsc_host_model_inst.rd(`ATSC_ADR_STATUS, d, oe);
        check("unsel_oe", {7'h0, oe}, 8'h00);
        atsc_host_model_inst.wr(`ATSC_ADR_STATUS, 8'h20);
        check("unsel_cmd", 8'(n_start), 8'h01);
        atsc_host_model_inst.wr(`ATSC_ADR_DRVHEAD, 8'ha0);
        atsc_host_model_inst.wr(`ATSC_ADR_SHADOW, 8'h0c);
        check("soft_reset_bit", 8'(n_soft_reset_bit), 8'h01);
        pulse(1'b1);
        atsc_host_model_inst.wr(`ATSC_ADR_SHADOW, 8'h08);
        $display("select and soft reset tests done");
        pulse(1'b0);
        repeat (3) @(posedge clk_in);
        check("irq", {6'h0, host_interrupt_pin_out,
            host_interrupt_pin_oe_out}, 8'h03);
        atsc_host_model_inst.rd(`ATSC_ADR_SHADOW, d, oe);
        check("irq_alt", {7'h0, host_interrupt_pin_out}, 8'h01);
        atsc_host_model_inst.rd(`ATSC_ADR_STATUS, d, oe);
        check("irq_clr", {7'h0, host_interrupt_pin_out}, 8'h00);
        atsc_host_model_inst.wr(`ATSC_ADR_SHADOW, 8'h0a);
        pulse(1'b0);
        repeat (3) @(posedge clk_in);
        check("irq_off", {7'h0, host_interrupt_pin_oe_out}, 8'h00);
        #1;
        memory_mode_in = 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        check("irq_mem", {6'h0, host_interrupt_pin_out,
            host_interrupt_pin_oe_out}, 8'h03);
        $display("interrupt test done");
        unit_identity_config_in = 1'b1;
        atsc_host_model_inst.wr(`ATSC_ADR_DRVHEAD, 8'hb0);
        atsc_host_model_inst.rd(`ATSC_ADR_READBACK, d, oe);
        check("rb_unit1", {oe, d[6:0]}, 8'hfd);
        check("rb_bit7", {7'h0, readback_bit7_oe_out}, 8'h00);
        $display("unit one test done");
        finish_test();
    end
endmodule
